// file: src/fsp_pkg.sv
// Package of register map, field positions and timing constants.
package fsp_pkg;
  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00; // serial_control_reg
  localparam logic [7:0] OFS_STAT   = 8'h04; // serial_status_reg
  localparam logic [7:0] OFS_FCTRL  = 8'h08; // fifo_control_reg
  localparam logic [7:0] OFS_FCOUNT = 8'h0c; // fifo_count_reg
  localparam logic [7:0] OFS_TXDATA = 8'h10; // tx_fifo_data_reg
  localparam logic [7:0] OFS_RXDATA = 8'h14; // rx_fifo_data_reg
  localparam logic [7:0] OFS_PORT   = 8'h18; // serial_port_pin_reg
  localparam logic [7:0] OFS_BAUD   = 8'h1c; // base clock divisor
  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int CTRL_TE    = 0;
  localparam int CTRL_RE    = 1;
  localparam int CTRL_TIE   = 2;
  localparam int CTRL_PEN   = 3;
  localparam int CTRL_ODD   = 4;
  localparam int STAT_TX_FIFO_EMPTY_FLAG  = 0;
  localparam int STAT_RDF   = 1;
  localparam int STAT_FER   = 2;
  localparam int STAT_PER   = 3;
  localparam int STAT_BRK   = 4;
  localparam int FCTRL_TTRG = 4;   // two bits [5:4]
  localparam int FCTRL_RTRG = 6;   // two bits [7:6]
  localparam int PORT_TXDT  = 0;
  localparam int PORT_TXIO  = 1;
  localparam int PORT_RTS_PIN_LEVEL_BIT = 2;
  localparam int PORT_RTS_PIN_DIRECTION_BIT = 3;
  // ---------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------
  localparam logic [4:0] CTRL_RST  = 5'h00;
  localparam logic [7:0] FCTRL_RST = 8'h00;
  localparam logic [3:0] PORT_RST  = 4'h0;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [4:0] OVERSAMPLE  = 5'h10; // base ticks per bit
  localparam logic [3:0] SAMPLE_TICK = 4'h7;  // eighth tick, counted from 0
  // Trigger levels selected by the two-bit fields.
  localparam logic [4:0] TX_TRIG0 = 5'h08;
  localparam logic [4:0] TX_TRIG1 = 5'h04;
  localparam logic [4:0] TX_TRIG2 = 5'h02;
  localparam logic [4:0] TX_TRIG3 = 5'h00;
  localparam logic [4:0] RX_TRIG0 = 5'h01;
  localparam logic [4:0] RX_TRIG1 = 5'h04;
  localparam logic [4:0] RX_TRIG2 = 5'h08;
  localparam logic [4:0] RX_TRIG3 = 5'h0e;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} fsp_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} fsp_rx_e;
endpackage : fsp_pkg

// file: src/fsp_fifo_serial_port.sv
// Serial port with FIFOs, threshold flags, break and pin control.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Tx empty flag sets when tx count falls below the tx trigger.
// - Clearing tx empty flag at count at or below trigger re-sets it.
// - Tx FIFO byte count reads in bits 15:8 of count register.
// - Rx full flag sets when rx count reaches the rx trigger.
// - Clearing rx full flag while count still at trigger re-sets it.
// - Rx FIFO byte count reads in lower eight bits of count register.
// - Break sets framing error, stops FIFO loading, receiver keeps running.
// - With transmit enable clear, tx pin direction and level come from port register bits.
// - Before transmit enable the pin level bit drives the idle level.
// - Clearing transmit enable resets transmitter; pin shows level bit.
// - Receiver runs on base clock at sixteen times bit rate.
// - Start fall found on base clock; bits latched on eighth tick.
// - With transmit enable clear, pins are driven only when their port direction bits are set.
// - Start bit goes out immediately after transmit enable is set.
// - Error flags set on bad character, clear when it is read out.
// - Independent sixteen-byte transmit and receive FIFOs.
// - Tx interrupt request is tx interrupt enable and tx empty flag.
module fsp_fifo_serial_port
  import fsp_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial pins
  input  wire logic        rx_pin_i,
  output logic             tx_pin_o,
  output logic             tx_pin_oe,
  output logic             rts_pin_o,
  output logic             rts_pin_oe,
  // Transmit request
  output logic             tx_empty_interrupt
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = AW'(DEPTH) == '0 ?
                                    {1'b1, {AW{1'b0}}} : (AW+1)'(DEPTH);
  // -------------------------------------------------------------------
  // Register bus
  // -------------------------------------------------------------------
  logic [7:0]  wr_addr_r, rd_addr_r;
  logic        wr_pend_r, rd_pend_r;
  logic [31:0] hrdata_r;
  logic [4:0]  ctrl_r;
  logic [7:0]  fctrl_r;
  logic [3:0]  port_r;
  logic [15:0] baud_r;
  logic        tx_fifo_empty_flag_r, rdf_r, fer_r, per_r, brk_r;
  logic [AW:0] tx_cnt_r, rx_cnt_r;
  logic [9:0]  rx_head;
  logic        accept, wr_en, rd_en, push_tx, pop_rx;
  logic        tx_pop, rx_push;
  logic [9:0]  rx_word;
  logic [31:0] rd_mux;

  assign accept    = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_pend_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign wr_en     = wr_pend_r;
  assign rd_en     = rd_pend_r;
  assign push_tx   = wr_en & (wr_addr_r == OFS_TXDATA) & (tx_cnt_r != DEPTH_C);
  assign pop_rx    = rd_en & (rd_addr_r == OFS_RXDATA) & (rx_cnt_r != '0);

  // Address phase capture; reads take one wait state.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= accept & hwrite;
      rd_pend_r <= accept & ~hwrite;
      if (accept) begin
        wr_addr_r <= {haddr[7:2], 2'b00};
        rd_addr_r <= {haddr[7:2], 2'b00};
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_mux = 32'h0;
    case (rd_addr_r)
      OFS_CTRL:   rd_mux = {27'h0, ctrl_r};
      OFS_STAT:   rd_mux = {27'h0, brk_r, per_r, fer_r, rdf_r, tx_fifo_empty_flag_r};
      OFS_FCTRL:  rd_mux = {24'h0, fctrl_r};
      OFS_FCOUNT: rd_mux = {16'h0, 8'(tx_cnt_r), 8'(rx_cnt_r)};
      OFS_RXDATA: rd_mux = {22'h0, rx_head};
      OFS_PORT:   rd_mux = {28'h0, port_r};
      OFS_BAUD:   rd_mux = {16'h0, baud_r};
      default:    rd_mux = 32'h0;
    endcase
  end

  // Read data register, loaded in the wait cycle.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) hrdata_r <= 32'h0;
    else if (rd_en) hrdata_r <= rd_mux;
  end

  // Control registers written in the data phase.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r  <= CTRL_RST;
      fctrl_r <= FCTRL_RST;
      port_r  <= PORT_RST;
      baud_r  <= BAUD_RST;
    end else if (wr_en) begin
      case (wr_addr_r)
        OFS_CTRL:  ctrl_r  <= hwdata[4:0];
        OFS_FCTRL: fctrl_r <= hwdata[7:0];
        OFS_PORT:  port_r  <= hwdata[3:0];
        OFS_BAUD:  baud_r  <= hwdata[15:0];
        default:   ctrl_r  <= ctrl_r;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // FIFOs
  // -------------------------------------------------------------------
  logic [7:0] tx_mem [DEPTH];
  logic [9:0] rx_mem [DEPTH];
  logic [AW-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic te;
  assign te      = ctrl_r[CTRL_TE];
  assign rx_head = rx_mem[rx_rp_r];

  always_ff @(posedge ref_clk) begin
    if (push_tx) tx_mem[tx_wp_r] <= hwdata[7:0];
    if (rx_push) rx_mem[rx_wp_r] <= rx_word;
  end

  // Pointers and fill counts of both FIFOs.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      rx_wp_r  <= '0;
      rx_rp_r  <= '0;
      tx_cnt_r <= '0;
      rx_cnt_r <= '0;
    end else begin
      if (push_tx) tx_wp_r <= tx_wp_r + 1'b1;
      if (tx_pop)  tx_rp_r <= tx_rp_r + 1'b1;
      if (rx_push) rx_wp_r <= rx_wp_r + 1'b1;
      if (pop_rx)  rx_rp_r <= rx_rp_r + 1'b1;
      tx_cnt_r <= tx_cnt_r + (AW+1)'(push_tx) - (AW+1)'(tx_pop);
      rx_cnt_r <= rx_cnt_r + (AW+1)'(rx_push) - (AW+1)'(pop_rx);
    end
  end

  // -------------------------------------------------------------------
  // Threshold and error flags
  // -------------------------------------------------------------------
  logic [4:0] tx_trig, rx_trig;
  logic       stat_wr, tx_below, tx_atbel, rx_reach;
  logic       rx_err_f, rx_err_p, rx_brk;

  // Trigger level decode.
  always_comb begin
    case (fctrl_r[FCTRL_TTRG +: 2])
      2'h0:    tx_trig = TX_TRIG0;
      2'h1:    tx_trig = TX_TRIG1;
      2'h2:    tx_trig = TX_TRIG2;
      default: tx_trig = TX_TRIG3;
    endcase
    case (fctrl_r[FCTRL_RTRG +: 2])
      2'h0:    rx_trig = RX_TRIG0;
      2'h1:    rx_trig = RX_TRIG1;
      2'h2:    rx_trig = RX_TRIG2;
      default: rx_trig = RX_TRIG3;
    endcase
  end

  assign stat_wr  = wr_en & (wr_addr_r == OFS_STAT);
  assign tx_below = 5'(tx_cnt_r) < tx_trig;
  assign tx_atbel = 5'(tx_cnt_r) <= tx_trig;
  assign rx_reach = 5'(rx_cnt_r) >= rx_trig;

  // Status flags; a set condition always wins over a clear write.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_fifo_empty_flag_r <= 1'b1;
      rdf_r  <= 1'b0;
      fer_r  <= 1'b0;
      per_r  <= 1'b0;
      brk_r  <= 1'b0;
    end else begin
      if (tx_below) tx_fifo_empty_flag_r <= 1'b1;
      else if (stat_wr && !hwdata[STAT_TX_FIFO_EMPTY_FLAG]) tx_fifo_empty_flag_r <= tx_atbel;
      if (rx_reach) rdf_r <= 1'b1;
      else if (stat_wr && !hwdata[STAT_RDF]) rdf_r <= 1'b0;
      if (rx_brk) brk_r <= 1'b1;
      else if (stat_wr && !hwdata[STAT_BRK]) brk_r <= 1'b0;
      // error flags follow the bad character
      if (rx_err_f) fer_r <= 1'b1;
      else if (pop_rx && rx_head[8]) fer_r <= 1'b0;
      if (rx_err_p) per_r <= 1'b1;
      else if (pop_rx && rx_head[9]) per_r <= 1'b0;
    end
  end

  assign tx_empty_interrupt = ctrl_r[CTRL_TIE] & tx_fifo_empty_flag_r;

  // -------------------------------------------------------------------
  // Base clock
  // -------------------------------------------------------------------
  logic [15:0] div_r;
  logic        tick;
  // base tick at sixteen per bit
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) div_r <= 16'h0;
    else if (div_r >= baud_r) div_r <= 16'h0;
    else div_r <= div_r + 16'h1;
  end
  assign tick = (div_r >= baud_r);

  // -------------------------------------------------------------------
  // Transmitter
  // -------------------------------------------------------------------
  fsp_tx_e    tx_st_r;
  logic [3:0] tx_tk_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic       tx_par_r, tx_line, tx_end;
  assign tx_pop = (tx_st_r == TX_IDLE) & te & (tx_cnt_r != '0);
  assign tx_end = tick & (tx_tk_r == 4'hf);

  // cleared enable resets at once; start without delay
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_st_r  <= TX_IDLE;
      tx_tk_r  <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_sh_r  <= 8'h00;
      tx_par_r <= 1'b0;
    end else if (!te) begin
      tx_st_r <= TX_IDLE;
      tx_tk_r <= 4'h0;
    end else begin
      if (tx_st_r != TX_IDLE && tick) tx_tk_r <= tx_tk_r + 4'h1;
      case (tx_st_r)
        TX_IDLE: if (tx_pop) begin
          tx_st_r  <= TX_START;
          tx_sh_r  <= tx_mem[tx_rp_r];
          tx_par_r <= ^tx_mem[tx_rp_r] ^ ctrl_r[CTRL_ODD];
          tx_bit_r <= 3'h0;
          tx_tk_r  <= 4'h0;
        end
        TX_START: if (tx_end) tx_st_r <= TX_DATA;
        TX_DATA: if (tx_end) begin
          tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
          tx_bit_r <= tx_bit_r + 3'h1;
          if (tx_bit_r == 3'h7)
            tx_st_r <= ctrl_r[CTRL_PEN] ? TX_PAR : TX_STOP;
        end
        TX_PAR:  if (tx_end) tx_st_r <= TX_STOP;
        TX_STOP: if (tx_end) tx_st_r <= TX_IDLE;
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // Line level produced by the transmitter.
  always_comb begin
    case (tx_st_r)
      TX_START: tx_line = 1'b0;
      TX_DATA:  tx_line = tx_sh_r[0];
      TX_PAR:   tx_line = tx_par_r;
      default:  tx_line = 1'b1;
    endcase
  end

  // pin drive from enable and port bits
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_pin_o   <= 1'b1;
      tx_pin_oe  <= 1'b0;
      rts_pin_o  <= 1'b1;
      rts_pin_oe <= 1'b0;
    end else begin
      tx_pin_o   <= te ? tx_line : port_r[PORT_TXDT];
      tx_pin_oe  <= te | port_r[PORT_TXIO];
      rts_pin_o  <= port_r[PORT_RTS_PIN_DIRECTION_BIT] ? port_r[PORT_RTS_PIN_LEVEL_BIT] : 1'b0;
      rts_pin_oe <= te | port_r[PORT_RTS_PIN_DIRECTION_BIT];
    end
  end

  // -------------------------------------------------------------------
  // Receiver
  // -------------------------------------------------------------------
  logic       rx_s1_r, rx_s2_r, rx_prev_r;
  fsp_rx_e    rx_st_r;
  logic [3:0] rx_tk_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic       rx_par_r, samp, ferr, perr;

  // Two-stage synchroniser for the receive pin.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= rx_pin_i;
      rx_s2_r <= rx_s1_r;
    end
  end

  assign samp  = tick & (rx_tk_r == SAMPLE_TICK);
  assign ferr  = ~rx_s2_r;
  assign perr  = ctrl_r[CTRL_PEN] &
                 (rx_par_r != (^rx_sh_r ^ ctrl_r[CTRL_ODD]));
  assign rx_brk  = samp & (rx_st_r == RX_STOP) & ferr &
                   (rx_sh_r == 8'h00) & ~(ctrl_r[CTRL_PEN] & rx_par_r);
  assign rx_err_f = samp & (rx_st_r == RX_STOP) & ferr;
  assign rx_err_p = samp & (rx_st_r == RX_STOP) & perr;
  // break is flagged but never stored
  assign rx_push  = samp & (rx_st_r == RX_STOP) & ~rx_brk &
                    (rx_cnt_r != DEPTH_C);
  assign rx_word  = {perr, ferr, rx_sh_r};

  // start fall on base tick, sample on eighth tick
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_st_r   <= RX_IDLE;
      rx_prev_r <= 1'b1;
      rx_tk_r   <= 4'h0;
      rx_bit_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_par_r  <= 1'b0;
    end else if (!ctrl_r[CTRL_RE]) begin
      rx_st_r   <= RX_IDLE;
      rx_prev_r <= 1'b1;
    end else if (tick) begin
      rx_prev_r <= rx_s2_r;
      rx_tk_r   <= rx_tk_r + 4'h1;
      case (rx_st_r)
        RX_IDLE: if (rx_prev_r && !rx_s2_r) begin
          rx_st_r <= RX_START;
          rx_tk_r <= 4'h0;
        end
        RX_START: if (samp) begin
          rx_st_r  <= rx_s2_r ? RX_IDLE : RX_DATA;
          rx_bit_r <= 3'h0;
        end
        RX_DATA: if (samp) begin
          rx_sh_r  <= {rx_s2_r, rx_sh_r[7:1]};
          rx_bit_r <= rx_bit_r + 3'h1;
          if (rx_bit_r == 3'h7)
            rx_st_r <= ctrl_r[CTRL_PEN] ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (samp) begin
          rx_par_r <= rx_s2_r;
          rx_st_r  <= RX_STOP;
        end
        RX_STOP: if (samp) rx_st_r <= RX_IDLE;
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  AST_TX_FIFO_EMPTY_FLAG_BELOW: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_below |=> tx_fifo_empty_flag_r) else $error("tx empty flag not set");
  AST_TX_FIFO_EMPTY_FLAG_RESET: assert property (@(posedge ref_clk) disable iff (!resetn)
    stat_wr && !hwdata[STAT_TX_FIFO_EMPTY_FLAG] && tx_atbel |=> tx_fifo_empty_flag_r)
    else $error("tx empty flag not re-set");
  AST_RDF_REACH: assert property (@(posedge ref_clk) disable iff (!resetn)
    rx_reach |=> rdf_r) else $error("rx full flag not set");
  AST_COUNT: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_en && rd_addr_r == OFS_FCOUNT |=>
    hrdata[15:8] == 8'($past(tx_cnt_r)) && hrdata[7:0] == 8'($past(rx_cnt_r)))
    else $error("count register mismatch");
  AST_BRK_NOPUSH: assert property (@(posedge ref_clk) disable iff (!resetn)
    rx_brk |-> !rx_push ##1 fer_r) else $error("break stored");
  AST_TXPIN: assert property (@(posedge ref_clk) disable iff (!resetn)
    !te ##1 !te |-> tx_pin_o == $past(port_r[PORT_TXDT]))
    else $error("tx pin level wrong");
  AST_TE_RESET: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(te) |=> tx_st_r == TX_IDLE) else $error("tx not reset");
  AST_START_NOW: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_pop |=> tx_st_r == TX_START ##1 !tx_pin_o)
    else $error("start bit late");
  AST_FER_CLR: assert property (@(posedge ref_clk) disable iff (!resetn)
    pop_rx && rx_head[8] && !rx_err_f |=> !fer_r)
    else $error("framing flag not cleared");
  AST_TXI: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_below && ctrl_r[CTRL_TIE] ##1 ctrl_r[CTRL_TIE] |-> tx_empty_interrupt)
    else $error("tx request wrong");
  AST_FIFO_CAP: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_cnt_r <= DEPTH_C && rx_cnt_r <= DEPTH_C)
    else $error("fifo count over depth");
endmodule : fsp_fifo_serial_port

// file: tb/fsp_remote_device.sv
// Remote serial device model facing the transmit and receive lines.
`timescale 1ns/1ps
module fsp_remote_device #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input  wire logic ref_clk,
  // Serial lines
  input  wire logic tx_line,
  output logic      rx_line
);
  logic [7:0] got_q[$];

  // The receive line idles high outside frames.
  initial begin
    rx_line = 1'b1;
  end

  // Sends a start bit, eight data bits LSB first, then the stop level.
  // sixteen base ticks per bit
  task automatic send_frame(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line <= f[i];
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    rx_line <= 1'b1;
    repeat (BIT_CLKS) @(posedge ref_clk);
  endtask : send_frame

  // Sends a frame with a parity bit between the data and the stop level.
  task automatic send_par_frame(input logic [7:0] d, input logic par,
                                input logic stop);
    logic [10:0] f;
    f = {stop, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    rx_line <= 1'b1;
    repeat (BIT_CLKS) @(posedge ref_clk);
  endtask : send_par_frame

  // Catches transmitted characters by sampling each bit mid-way.
  always begin : catch_tx
    logic [7:0] b;
    @(negedge tx_line);
    repeat (BIT_CLKS / 2) @(posedge ref_clk);
    if (tx_line == 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge ref_clk);
        b[i] = tx_line;
      end
      repeat (BIT_CLKS) @(posedge ref_clk);
      got_q.push_back(b);
    end
  end
endmodule : fsp_remote_device

// file: tb/tb_top.sv
// Self-checking testbench for the FIFO serial port.
`timescale 1ns/1ps
module tb_top
  import fsp_pkg::*;
;
  // -------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------
  logic        ref_clk, resetn, hsel, hwrite, hresp, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        rx_line, tx_pin_o, tx_pin_oe, rts_pin_o, rts_pin_oe;
  logic        tx_empty_interrupt;
  wire logic   tx_line;
  logic [4:0]  p;
  int          n_fail, checks_done, k, n, m;
  int          txl[4] = '{TX_TRIG0, TX_TRIG1, TX_TRIG2, TX_TRIG3};
  int          rxl[4] = '{RX_TRIG0, RX_TRIG1, RX_TRIG2, RX_TRIG3};

  // One pin per line; an undriven line reads high at the far end.
  assign tx_line = tx_pin_oe ? tx_pin_o : 1'b1;

  fsp_fifo_serial_port #(.DEPTH(16)) u_fsp_fifo_serial_port (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_pin_i(rx_line), .tx_pin_o(tx_pin_o),
    .tx_pin_oe(tx_pin_oe), .rts_pin_o(rts_pin_o), .rts_pin_oe(rts_pin_oe),
    .tx_empty_interrupt(tx_empty_interrupt));

  fsp_remote_device #(.BIT_CLKS(16)) u_fsp_remote_device (
    .ref_clk(ref_clk), .tx_line(tx_line), .rx_line(rx_line));

  // 20 MHz clock.
  always #25 ref_clk = ~ref_clk;

  // -------------------------------------------------------------------
  // Bus and check tasks
  // -------------------------------------------------------------------
  // Waits for a ready edge, capturing read data sampled before it.
  task automatic wait_ready(output logic [31:0] rd);
    logic r;
    do begin
      @(negedge ref_clk);
      r = hreadyout;
      rd = hrdata;
      @(posedge ref_clk);
    end while (r !== 1'b1);
  endtask : wait_ready

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= 1'b1;
    wait_ready(x);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    wait_ready(x);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] rd);
    logic [31:0] x;
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= 1'b0;
    wait_ready(x);
    hsel <= 1'b0; htrans <= 2'b00;
    wait_ready(rd);
  endtask : bus_rd

  // Samples the pin outputs at a falling edge after n cycles.
  task automatic look(input int c);
    repeat (c) @(negedge ref_clk);
    p = {tx_empty_interrupt, rts_pin_oe, rts_pin_o, tx_pin_oe, tx_pin_o};
    @(posedge ref_clk);
  endtask : look

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Cuts a hang short well past the expected run length.
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end

  // -------------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0; resetn = 1'b0; hsel = 1'b0; haddr = 32'h0;
    htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0;
    n_fail = 0; checks_done = 0; m = 0; n = 0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    // Reset values, an unmapped offset and undriven pins.
    look(1); chk({27'h0, p}, 32'h0);
    bus_rd(OFS_STAT, d); chk(d, 32'h1);
    bus_rd(OFS_FCOUNT, d); chk(d, 32'h0);
    bus_rd(8'h20, d); chk(d, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    // Pin level and direction bits drive the idle lines.
    bus_wr(OFS_PORT, 32'hf); look(2); chk({27'h0, p}, 32'hf);
    // Every tx trigger level: clear re-sets at the level, clears above it.
    for (int s = 3; s >= 0; s--) begin
      bus_wr(OFS_FCTRL, 32'(s << 4));
      while (n < txl[s]) begin
        bus_wr(OFS_TXDATA, 32'(8'h40 + n)); n++;
      end
      bus_wr(OFS_STAT, 32'h12); bus_rd(OFS_STAT, d);
      chk(d & 32'h1, 32'h1);
      bus_wr(OFS_TXDATA, 32'(8'h40 + n)); n++;
      bus_wr(OFS_STAT, 32'h12); bus_rd(OFS_STAT, d);
      chk(d & 32'h1, 32'h0);
      bus_rd(OFS_FCOUNT, d); chk(d >> 8, 32'(n));
    end
    bus_wr(OFS_CTRL, 32'h4); look(1); chk({31'h0, p[4]}, 32'h0);
    // Start bit follows transmit enable at once.
    bus_wr(OFS_CTRL, 32'h5); k = 0;
    do begin look(1); k++; end while (p[0] !== 1'b0 && k < 8);
    chk({31'h0, p[0]}, 32'h0);
    k = 0;
    do begin look(1); k++; end while (p[4] !== 1'b1 && k < 3000);
    chk({31'h0, p[4]}, 32'h1);
    bus_rd(OFS_FCOUNT, d); chk(d >> 8, 32'h7);
    chk({24'h0, u_fsp_remote_device.got_q[0]}, 32'h40);
    // Break in mid-transmission: level bit low, then disable.
    bus_wr(OFS_PORT, 32'h2); bus_wr(OFS_CTRL, 32'h4);
    look(2); chk({30'h0, p[1:0]}, 32'h2);
    look(40); chk({30'h0, p[1:0]}, 32'h2);
    bus_wr(OFS_PORT, 32'h3); look(2); chk({30'h0, p[1:0]}, 32'h3);
    bus_wr(OFS_PORT, 32'h0); look(2); chk({30'h0, p[1:0]}, 32'h0);
    // Every rx trigger level: flag, re-set on clear, drain, clear.
    bus_wr(OFS_CTRL, 32'h2);
    for (int s = 0; s < 4; s++) begin
      bus_wr(OFS_FCTRL, 32'(s << 6));
      for (int j = 0; j < rxl[s]; j++) begin
        bus_rd(OFS_STAT, d); chk(d & 32'h2, 32'h0);
        u_fsp_remote_device.send_frame(8'(8'h5a + m + j), 1'b1);
      end
      bus_rd(OFS_STAT, d); chk(d & 32'h2, 32'h2);
      bus_rd(OFS_FCOUNT, d); chk(d & 32'hff, 32'(rxl[s]));
      bus_wr(OFS_STAT, 32'h11); bus_rd(OFS_STAT, d);
      chk(d & 32'h2, 32'h2);
      for (int j = 0; j < rxl[s]; j++) begin
        bus_rd(OFS_RXDATA, d); chk(d & 32'h3ff, 32'(8'h5a + m));
        m++;
      end
      bus_wr(OFS_STAT, 32'h11); bus_rd(OFS_STAT, d);
      chk(d & 32'h2, 32'h0);
    end
    // Bad stop bit: flag set, kept with the char, cleared on pop.
    u_fsp_remote_device.send_frame(8'h3c, 1'b0);
    bus_rd(OFS_STAT, d); chk(d & 32'h4, 32'h4);
    bus_rd(OFS_RXDATA, d); chk(d & 32'h3ff, 32'h13c);
    bus_rd(OFS_STAT, d); chk(d & 32'h4, 32'h0);
    // Line break: flagged, not stored, receiver keeps running.
    u_fsp_remote_device.send_frame(8'h00, 1'b0);
    bus_rd(OFS_STAT, d); chk(d & 32'h1c, 32'h14);
    bus_rd(OFS_FCOUNT, d); chk(d & 32'hff, 32'h0);
    u_fsp_remote_device.send_frame(8'h69, 1'b1);
    bus_rd(OFS_FCOUNT, d); chk(d & 32'hff, 32'h1);
    bus_rd(OFS_RXDATA, d); chk(d & 32'h3ff, 32'h69);
    // Even parity with a wrong bit, then odd parity with a right bit.
    bus_wr(OFS_CTRL, 32'ha);
    u_fsp_remote_device.send_par_frame(8'h69, 1'b1, 1'b1);
    bus_rd(OFS_STAT, d); chk(d & 32'h8, 32'h8);
    bus_rd(OFS_RXDATA, d); chk(d & 32'h3ff, 32'h269);
    bus_rd(OFS_STAT, d); chk(d & 32'h8, 32'h0);
    bus_wr(OFS_CTRL, 32'h1a);
    u_fsp_remote_device.send_par_frame(8'h69, 1'b1, 1'b1);
    bus_rd(OFS_RXDATA, d); chk(d & 32'h3ff, 32'h69);
    bus_rd(OFS_STAT, d); chk(d & 32'h8, 32'h0);
    end_of_test();
  end
endmodule : tb_top
